/* hw/srh_read_handshake.sv */
/*
 * read-handshake status byte of a serial-to-fieldbus slave: moves blocks
 * from the receive buffer into the input image, one per master ack.
 * assumes the receive buffer offers a whole block with its length, and
 * that the master toggles its ack bit after each read.
 */
// Operation
// - low five bits give valid byte count
// - fresh flag set on each block load
// - fresh flag clears after configurable timeout
// - pending flag mirrors receive buffer non-empty
// - toggle bit inverts on every block load
// - loads happen only while device ready
`timescale 1ns/1ps
`default_nettype none
`include "srh_cfg.svh"
module srh_read_handshake
    import srh_pkg::*;
#(
    parameter logic [`SRH_TMO_W-1:0] TIMEOUT_CYC = `SRH_TMO_W'(`SRH_FRESH_CYC)
) (
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic DEV_READY,
    input wire logic READ_ACK,
    input wire logic RXB_VALID,
    input wire logic [`SRH_CNT_W-1:0] RXB_COUNT,
    input wire logic [8*`SRH_IMG_BYTES-1:0] RXB_DATA,
    input wire logic RXB_MORE,
    output logic RXB_POP,
    output logic [7:0] STATUS_BYTE,
    output logic [8*`SRH_IMG_BYTES-1:0] RX_DATA
);
    ////////////////////////////////////////////////////////////////////////
    srh_state_t state_r, state_nxt;
    logic [`SRH_CNT_W-1:0] cnt_r, cnt_nxt;
    logic [8*`SRH_IMG_BYTES-1:0] data_r, data_nxt;
    logic fresh_r, fresh_nxt;
    logic pend_r, pend_nxt;
    logic tog_r, tog_nxt;
    logic ack_seen_r, ack_seen_nxt;
    logic pop_r, pop_nxt;
    logic load;

    srh_tmo_if tmo_bus ();

    srh_fresh_timer #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_timer (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .tmo(tmo_bus)
    );

    // a block is taken only when ready, idle and the buffer offers one
    assign load = (state_r == SRH_IDLE) && DEV_READY && RXB_VALID;
    assign tmo_bus.start = load;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        data_nxt = data_r;
        fresh_nxt = fresh_r;
        tog_nxt = tog_r;
        ack_seen_nxt = ack_seen_r;
        pop_nxt = 1'b0;
        // buffer level is reported even when idle or not ready
        pend_nxt = RXB_MORE | (RXB_VALID & ~load);
        if (tmo_bus.expired) begin
            fresh_nxt = 1'b0;
        end
        unique case (state_r)
            SRH_IDLE: begin
                if (load) begin
                    // count, data, toggle and fresh flag change on the same edge: no torn data set
                    cnt_nxt = (RXB_COUNT > `SRH_MAX_BYTES) ?
                        `SRH_MAX_BYTES : RXB_COUNT;
                    data_nxt = RXB_DATA;
                    tog_nxt = ~tog_r;
                    fresh_nxt = 1'b1;
                    pop_nxt = 1'b1;
                    state_nxt = SRH_WAIT_ACK;
                end
            end
            SRH_WAIT_ACK: begin
                if (READ_ACK != ack_seen_r) begin
                    ack_seen_nxt = READ_ACK;
                    state_nxt = SRH_IDLE;
                end
            end
        endcase
        if (!DEV_READY) begin
            // leaving operation drops an outstanding wait; ack is resampled
            ack_seen_nxt = READ_ACK;
            state_nxt = SRH_IDLE;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            state_r <= SRH_IDLE;
            cnt_r <= '0;
            data_r <= '0;
            fresh_r <= 1'b0;
            pend_r <= 1'b0;
            tog_r <= 1'b0;
            ack_seen_r <= 1'b0;
            pop_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            data_r <= data_nxt;
            fresh_r <= fresh_nxt;
            pend_r <= pend_nxt;
            tog_r <= tog_nxt;
            ack_seen_r <= ack_seen_nxt;
            pop_r <= pop_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign STATUS_BYTE = {tog_r, pend_r, fresh_r, cnt_r};
    assign RX_DATA = data_r;
    assign RXB_POP = pop_r;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);

    sequence s_load;
        load;
    endsequence
    sequence s_done;
        tog_r != $past(tog_r) && fresh_r && pop_r;
    endsequence

    chk_load_toggles: assert property (s_load |=> s_done)
        else $error("toggle, fresh or pop missing after load");
    chk_count_cap: assert property (cnt_r <= `SRH_MAX_BYTES)
        else $error("byte count above image capacity");
    chk_count_value: assert property (load |=> cnt_r == ((
            $past(RXB_COUNT) > `SRH_MAX_BYTES) ? `SRH_MAX_BYTES :
            $past(RXB_COUNT)))
        else $error("byte count does not match loaded block");
    chk_atomic_set: assert property ($changed(data_r) |-> $changed(tog_r))
        else $error("data changed without toggle");
    chk_ready_gate: assert property ($changed(tog_r) |-> $past(DEV_READY))
        else $error("block loaded while not ready");
    chk_wait_ack: assert property (
            load |=> !load throughout (READ_ACK == ack_seen_r)[*2])
        else $error("new block without master ack");
    chk_pend_flag: assert property (
            (RXB_MORE && !SYS_RST) |=> pend_r)
        else $error("pending flag low while buffer holds data");
    chk_fresh_clear: assert property (
            tmo_bus.expired && !load |=> !fresh_r)
        else $error("fresh flag not cleared on timeout");

    ////////////////////////////////////////////////////////////////////////
    // guards on pulse shapes and on the quiet spans between loads

    // waiting for the master with no ack change and still in operation
    sequence s_waiting;
        state_r == SRH_WAIT_ACK && READ_ACK == ack_seen_r && DEV_READY;
    endsequence

    // toggle, count and data may not move, while fresh and pending still may: no pop, no new data set
    sequence s_quiet;
        !pop_r && $stable(tog_r) && $stable(cnt_r) && $stable(data_r);
    endsequence

    // the buffer neither offers a block nor holds anything behind it
    sequence s_buffer_empty;
        !RXB_MORE && !RXB_VALID;
    endsequence

    chk_pop_pulse: assert property (pop_r |=> !pop_r)
        else $error("pop held longer than one cycle");

    // a master that has not acked must see the old set unchanged
    chk_hold_wait: assert property (s_waiting |=> s_quiet)
        else $error("image changed while waiting for master ack");

    chk_fresh_set: assert property (load |=> fresh_r)
        else $error("fresh flag not set after load");

    // fresh only rises through a load, never on its own
    chk_fresh_rise: assert property ($rose(fresh_r) |-> $past(load))
        else $error("fresh flag rose without a load");

    // fresh may only fall on a timer expiry
    chk_fresh_hold: assert property (
            fresh_r && !tmo_bus.expired |=> fresh_r)
        else $error("fresh flag dropped before timeout");

    chk_pend_empty: assert property (s_buffer_empty |=> !pend_r)
        else $error("pending flag high with empty buffer");

    chk_pop_load: assert property (pop_r |-> $past(load))
        else $error("pop without a preceding load");

    // out of operation the image must stay frozen
    chk_idle_quiet: assert property (
            !DEV_READY |=> !pop_r && $stable(tog_r))
        else $error("block moved while not ready");
endmodule : srh_read_handshake
`default_nettype wire

/* common/srh_cfg.svh */
/*
 * constants of the read-handshake block: status byte layout, image size,
 * fresh-data timeout. assumes a 40 MHz system clock.
 */
`ifndef SRH_CFG_SVH
`define SRH_CFG_SVH
`define SRH_STATUS_OFFSET 8'h01
`define SRH_CNT_W 5
`define SRH_MAX_BYTES 5'h12
`define SRH_IMG_BYTES 18
`define SRH_FRESH_BIT 5
`define SRH_PEND_BIT 6
`define SRH_TOGGLE_BIT 7
`define SRH_STATUS_RESET 8'h00
`define SRH_CLK_HZ 40000000
`define SRH_FRESH_MS 500
`define SRH_FRESH_CYC ((`SRH_CLK_HZ / 1000) * `SRH_FRESH_MS)
`define SRH_TMO_W 25
`endif

/* common/srh_pkg.sv */
/*
 * types of the read-handshake block.
 * assumes srh_cfg.svh is on the include path.
 */
package srh_pkg;
    typedef enum logic [1:0] {SRH_IDLE, SRH_WAIT_ACK} srh_state_t;
    typedef logic [7:0] srh_byte_t;
endpackage : srh_pkg

/* common/srh_tmo_if.sv */
/*
 * interface between the handshake core and its fresh-data timer.
 * assumes one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
interface srh_tmo_if;
    logic start;
    logic expired;
    modport core (output start, input expired);
    modport timer (input start, output expired);
endinterface : srh_tmo_if
`default_nettype wire

/* hw/srh_fresh_timer.sv */
/*
 * fresh-data timer: restarts on start, pulses expired once after the
 * configured time. assumes a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "srh_cfg.svh"
module srh_fresh_timer #(
    parameter logic [`SRH_TMO_W-1:0] TIMEOUT_CYC = `SRH_TMO_W'(`SRH_FRESH_CYC)
) (
    input wire logic clk,
    input wire logic rst,
    srh_tmo_if.timer tmo
);
    logic [`SRH_TMO_W-1:0] cnt_r;
    logic [`SRH_TMO_W-1:0] cnt_nxt;
    logic exp_r;
    logic exp_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        exp_nxt = 1'b0;
        if (tmo.start) begin
            cnt_nxt = TIMEOUT_CYC;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - 1'b1;
            exp_nxt = (cnt_r == `SRH_TMO_W'(1));
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
            exp_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            exp_r <= exp_nxt;
        end
    end

    assign tmo.expired = exp_r;
endmodule : srh_fresh_timer
`default_nettype wire

/* verification/srh_master_model.sv */
/* cyclic master model: answers each block-ready change with an ack toggle.
   assumes the ack delay input is held steady while a reply is pending. */
`timescale 1ns/1ps
`default_nettype none
module srh_master_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic toggle_in,
    input wire logic [3:0] delay,
    output logic ack
);
    logic seen;
    int n;
    // fresh flag ignored, waits delay+1 clocks after a toggle change, then acks
    always @(posedge clk) begin
        if (rst) begin
            seen = 1'b0;
            ack <= 1'b0;
            n = -1;
        end else if (toggle_in !== seen) begin
            seen = toggle_in;
            n = delay;
        end else if (n == 0) begin
            ack <= ~ack;
            n = -1;
        end else if (n > 0) begin
            n = n - 1;
        end
    end
endmodule : srh_master_model
`default_nettype wire

/* verification/serial_rx_read_handshake_tb.sv */
/* bench for the read-handshake block: offers blocks, scores each load.
   assumes srh_cfg.svh on the include path and a 20-cycle fresh timeout. */
`timescale 1ns/1ps
`default_nettype none
`include "srh_cfg.svh"
module serial_rx_read_handshake_tb;
    logic clk = 0, rst = 1, rdy = 0, vld = 0, more = 0, pop, ack, tog = 1;
    logic [4:0] cnt = 0;
    logic [143:0] dat = 0, img;
    logic [7:0] st;
    logic [3:0] dly = 0;
    logic [148:0] q[$], e;
    logic last_ack = 0;
    logic [4:0] lens [5] = '{5'h00, 5'h01, 5'h12, 5'h13, 5'h1F};
    int mismatches = 0, checks_done = 0, acks = 0, pops = 0, p, k;
    srh_read_handshake #(.TIMEOUT_CYC(25'h14)) uut (.CLK_SYS(clk),
        .SYS_RST(rst), .DEV_READY(rdy), .READ_ACK(ack), .RXB_VALID(vld),
        .RXB_COUNT(cnt), .RXB_DATA(dat), .RXB_MORE(more), .RXB_POP(pop),
        .STATUS_BYTE(st), .RX_DATA(img));
    srh_master_model mst (.clk(clk), .rst(rst), .toggle_in(st[7]),
        .delay(dly), .ack(ack));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task chk(input logic [143:0] got, input logic [143:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    function automatic logic [143:0] msk(input logic [4:0] c);
        return (c >= 5'h12) ? '1 : ((144'h1 << (8 * c)) - 144'h1);
    endfunction : msk
    // a stalled offer is bounded so a lost pop shows up as a mismatch
    task offer(input logic [4:0] c, input logic m);
        @(posedge clk);
        #2;
        cnt = c;
        more = m;
        vld = 1;
        dat = 144'({$urandom, $urandom, $urandom, $urandom, $urandom});
        q.push_back({(c > 5'h12) ? 5'h12 : c, dat & msk(c)});
        for (k = 0; k < 60 && pop !== 1'b1; k++) @(negedge clk);
        @(posedge clk);
        #2 vld = 0;
        @(posedge clk);
        @(negedge clk);
        chk(st[6], m);
    endtask : offer
    ////////////////////////////////////////////////////////////////////////
    always @(negedge clk) begin
        if (ack !== last_ack) acks++;
        last_ack = ack;
        if (pop === 1'b1) begin
            if (q.size() == 0) begin
                mismatches++;
                $display("[ERR] t=%0t got=%0h exp=%0h", $time, 1, 0);
                e = '0;
            end else begin
                e = q.pop_front();
            end
            chk(pops, acks);
            chk(st[4:0], e[148:144]);
            chk(st[5], 1'b1);
            chk(st[7], tog);
            chk(img & msk(e[148:144]), e[143:0]);
            tog = ~tog;
            pops++;
        end
    end
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end
    initial begin
        k = $urandom(32'h523243CC);
        repeat (12) @(posedge clk);
        #2 rst = 0;
        rdy = 1;
        @(negedge clk);
        chk(st, `SRH_STATUS_RESET);
        chk(img, 144'h0);
        $display("test reset done");
        foreach (lens[i]) begin
            dly = 4'($urandom % 10);
            offer(lens[i], i[0]);
        end
        dly = 0;
        offer(5'($urandom % 19), 1'b1);
        $display("test loads done");
        repeat (12) @(posedge clk);
        #2 rdy = 0;
        p = pops;
        fork
            offer(5'h07, 1'b0);
            begin
                repeat (10) @(negedge clk);
                chk(pops, p);
                @(posedge clk);
                #2 rdy = 1;
            end
        join
        $display("test not ready done");
        repeat (14) @(negedge clk);
        chk(st[5], 1'b1);
        repeat (10) @(negedge clk);
        chk(st[5], 1'b0);
        $display("test fresh timeout done");
        report_and_stop();
    end
endmodule : serial_rx_read_handshake_tb
`default_nettype wire
